// File: logic/hefm_top.sv
/*
  haptic event flag and mask unit: status bits, three sticky event flag
  registers, three enable registers and a combined interrupt request.
  assumes register accesses arrive as single-cycle strobes from the device's
  serial slave, and all event inputs are synchronous to clk.
*/
//
// Function
// - the fault summary bit reads 1 while any fault keeps the driver locked, else 0.
// - the converter activity bit reads 1 while the converter is enabled and converting, 0 when disabled.
// - each driver fault flag bit sets when its per-fault status bit changes value.
// - the auto-tune complete flag sets when auto-tune finishes.
// - the vibration timeout flag sets on timeout expiry and the driver locks as a fault.
// - the supply undervoltage flag sets when the supply falls below lockout and the driver locks.
// - the fault summary change flag sets whenever the fault summary bit changes.
// - the converter activity change flag sets whenever the activity bit changes.
// - the conversion complete flag sets at each end of conversion.
// - the first enable register gates the driver fault flags bit for bit, 1 passing an event.
// - the second enable register bits 3..0 gate the misc flags, 1 passing an event.
// - the per-fault status register reports the eight driver conditions at bits 7..0.
// - the converter enable register gates the two converter flags, 1 passing an event.
`timescale 1ns/100ps
module hefm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [hefm_pkg::DATA_W-1:0] reg_wdata,
  output logic [hefm_pkg::DATA_W-1:0] reg_rdata_q,
  // event sources
  input wire logic [hefm_pkg::DATA_W-1:0] per_fault_status_in,
  input wire logic supply_undervoltage_in,
  input wire logic vibration_timeout_in,
  input wire logic autotune_done_in,
  input wire logic converter_enabled_in,
  input wire logic conversion_running_in,
  input wire logic conversion_end_in,
  // outputs
  output logic fault_summary_q,
  output logic converter_active_q,
  output logic irq_q
);
  import hefm_pkg::*;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic [DATA_W-1:0] per_fault_status_q;
  logic [DATA_W-1:0] status_prev_q;
  logic fault_prev_q;
  logic active_prev_q;
  logic uvlo_prev_q;
  logic armed_q;
  logic [DATA_W-1:0] fault_en_q;
  logic [MISC_W-1:0] misc_en_q;
  logic [CONV_W-1:0] conv_en_q;
  logic [DATA_W-1:0] fault_flags_q;
  logic [MISC_W-1:0] misc_flags_q;
  logic [CONV_W-1:0] conv_flags_q;

  // ==========================================================
  // address decode
  wire wr_fault_flags = reg_wr && hit(reg_addr, OFF_DRIVER_FAULT_EVENT_FLAGS);
  wire wr_misc_flags = reg_wr && hit(reg_addr, OFF_DRIVER_MISC_EVENT_FLAGS);
  wire wr_conv_flags = reg_wr && hit(reg_addr, OFF_CONVERTER_EVENT_FLAGS);
  wire wr_fault_en = reg_wr && hit(reg_addr, OFF_DRIVER_FAULT_EVENT_ENABLE);
  wire wr_misc_en = reg_wr && hit(reg_addr, OFF_DRIVER_MISC_EVENT_ENABLE);
  wire wr_conv_en = reg_wr && hit(reg_addr, OFF_CONVERTER_EVENT_ENABLE);

  // ==========================================================
  // status
  // fault summary source
  wire fault_d = (|per_fault_status_q[DATA_W-1:POS_FIRST_FAULT]) | supply_undervoltage_in
    | misc_flags_q[POS_VIBRATION_TIMEOUT];
  wire active_d = converter_enabled_in & conversion_running_in;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_fault_status_q <= RST_FLAGS;
      fault_summary_q <= 1'b0;
      converter_active_q <= 1'b0;
    end else begin
      per_fault_status_q <= per_fault_status_in;
      fault_summary_q <= fault_d;
      converter_active_q <= active_d;
    end
  end

  // history for change detection, armed one cycle after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_prev_q <= RST_FLAGS;
      fault_prev_q <= 1'b0;
      active_prev_q <= 1'b0;
      uvlo_prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      status_prev_q <= per_fault_status_q;
      fault_prev_q <= fault_summary_q;
      active_prev_q <= converter_active_q;
      uvlo_prev_q <= supply_undervoltage_in;
      armed_q <= 1'b1;
    end
  end

  // ==========================================================
  // flag sets
  // per-fault change
  wire [DATA_W-1:0] fault_chg = (per_fault_status_q ^ status_prev_q) & {DATA_W{armed_q}};
  wire [MISC_W-1:0] misc_set;
  wire [CONV_W-1:0] conv_set;
  assign misc_set[POS_AUTOTUNE_COMPLETE] = autotune_done_in;
  assign misc_set[POS_VIBRATION_TIMEOUT] = vibration_timeout_in;
  assign misc_set[POS_SUPPLY_UNDERVOLTAGE] = supply_undervoltage_in & ~uvlo_prev_q;
  assign misc_set[POS_FAULT_SUMMARY_CHANGE] = armed_q & (fault_summary_q ^ fault_prev_q);
  assign conv_set[POS_CONVERTER_ACTIVITY_CHANGE] = armed_q & (converter_active_q ^ active_prev_q);
  assign conv_set[POS_CONVERSION_COMPLETE] = conversion_end_in;

  // ==========================================================
  // sticky flags, write one to clear
  // write-one clear strobes
  hefm_flag_reg #(.WIDTH(DATA_W)) u_fault_flags (
    .clk(clk),
    .rst(rst),
    .set_in(fault_chg),
    .clr_in(reg_wdata & {DATA_W{wr_fault_flags}}),
    .flags_q(fault_flags_q)
  );
  hefm_flag_reg #(.WIDTH(MISC_W)) u_misc_flags (
    .clk(clk),
    .rst(rst),
    .set_in(misc_set),
    .clr_in(reg_wdata[MISC_W-1:0] & {MISC_W{wr_misc_flags}}),
    .flags_q(misc_flags_q)
  );
  hefm_flag_reg #(.WIDTH(CONV_W)) u_conv_flags (
    .clk(clk),
    .rst(rst),
    .set_in(conv_set),
    .clr_in(reg_wdata[CONV_W-1:0] & {CONV_W{wr_conv_flags}}),
    .flags_q(conv_flags_q)
  );

  // ==========================================================
  // enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_en_q <= RST_ENABLE;
      misc_en_q <= RST_ENABLE[MISC_W-1:0];
      conv_en_q <= RST_ENABLE[CONV_W-1:0];
    end else begin
      if (wr_fault_en) begin
        fault_en_q <= reg_wdata;
      end
      if (wr_misc_en) begin
        misc_en_q <= reg_wdata[MISC_W-1:0];
      end
      if (wr_conv_en) begin
        conv_en_q <= reg_wdata[CONV_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupt request
  // driver fault gating
  wire fault_pend = |(fault_flags_q & fault_en_q);
  wire misc_pend = |(misc_flags_q & misc_en_q);
  wire conv_pend = |(conv_flags_q & conv_en_q);
  wire irq_d = fault_pend | misc_pend | conv_pend;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // read data
  wire [DATA_W-1:0] rd_mux =
    hit(reg_addr, OFF_PER_FAULT_STATUS) ? per_fault_status_q :
    hit(reg_addr, OFF_FAULT_SUMMARY_STATUS) ? (DATA_W'(fault_summary_q) << POS_FAULT_SUMMARY) :
    hit(reg_addr, OFF_CONVERTER_ACTIVITY_STATUS) ? (DATA_W'(converter_active_q) << POS_CONVERTER_ACTIVE) :
    hit(reg_addr, OFF_DRIVER_FAULT_EVENT_FLAGS) ? fault_flags_q :
    hit(reg_addr, OFF_DRIVER_MISC_EVENT_FLAGS) ? DATA_W'(misc_flags_q) :
    hit(reg_addr, OFF_CONVERTER_EVENT_FLAGS) ? DATA_W'(conv_flags_q) :
    hit(reg_addr, OFF_DRIVER_FAULT_EVENT_ENABLE) ? fault_en_q :
    hit(reg_addr, OFF_DRIVER_MISC_EVENT_ENABLE) ? DATA_W'(misc_en_q) :
    hit(reg_addr, OFF_CONVERTER_EVENT_ENABLE) ? DATA_W'(conv_en_q) : UNMAPPED_RDATA;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  wire [DATA_W-1:0] fault_chg_raw = per_fault_status_q ^ status_prev_q;

  fault_summary_on_a: assert property (
    @(posedge clk) disable iff (rst)
    (|per_fault_status_q[DATA_W-1:POS_FIRST_FAULT]) |=> fault_summary_q)
    else $error("fault summary not set while a fault is present");

  converter_active_a: assert property (
    @(posedge clk) disable iff (rst)
    (converter_enabled_in && conversion_running_in) |=> converter_active_q ##0 $past(active_d))
    else $error("converter activity bit missed");

  converter_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !converter_enabled_in |=> !converter_active_q)
    else $error("converter activity bit set while disabled");

  fault_change_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    (armed_q && fault_chg_raw != '0) |=> ((fault_flags_q & $past(fault_chg_raw)) == $past(fault_chg_raw)))
    else $error("per-fault change did not set its flag");

  autotune_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    autotune_done_in |=> misc_flags_q[POS_AUTOTUNE_COMPLETE])
    else $error("auto-tune flag not set");

  timeout_lock_a: assert property (
    @(posedge clk) disable iff (rst)
    vibration_timeout_in |=> misc_flags_q[POS_VIBRATION_TIMEOUT] ##1 fault_summary_q)
    else $error("timeout did not flag and lock");

  uvlo_lock_a: assert property (
    @(posedge clk) disable iff (rst)
    (supply_undervoltage_in && !uvlo_prev_q) |=> misc_flags_q[POS_SUPPLY_UNDERVOLTAGE] && fault_summary_q)
    else $error("undervoltage did not flag and lock");

  summary_change_a: assert property (
    @(posedge clk) disable iff (rst)
    (armed_q && $changed(fault_summary_q)) |=> misc_flags_q[POS_FAULT_SUMMARY_CHANGE])
    else $error("fault summary change not flagged");

  activity_change_a: assert property (
    @(posedge clk) disable iff (rst)
    (armed_q && $changed(converter_active_q)) |=> conv_flags_q[POS_CONVERTER_ACTIVITY_CHANGE])
    else $error("activity change not flagged");

  conversion_end_a: assert property (
    @(posedge clk) disable iff (rst)
    conversion_end_in |=> conv_flags_q[POS_CONVERSION_COMPLETE])
    else $error("end of conversion not flagged");

  masked_quiet_a: assert property (
    @(posedge clk) disable iff (rst)
    (fault_en_q == '0 && misc_en_q == '0 && conv_en_q == '0) |=> !irq_q)
    else $error("interrupt raised with every enable at zero");

  irq_follow_a: assert property (
    @(posedge clk) disable iff (rst)
    (fault_pend || misc_pend || conv_pend) |=> irq_q)
    else $error("interrupt not raised for an enabled flag");

  flag_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !wr_fault_flags |=> ((fault_flags_q & $past(fault_flags_q)) == $past(fault_flags_q)))
    else $error("flag dropped without a clearing write");

endmodule // hefm_top

// File: logic/hefm_pkg.sv
/*
  constants for the haptic event flag and mask unit: register offsets,
  field positions, implemented bit widths and reset values.
  assumes nothing of its surroundings.
*/
package hefm_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_PER_FAULT_STATUS = 8'h00;
  localparam logic [7:0] OFF_FAULT_SUMMARY_STATUS = 8'h01;
  localparam logic [7:0] OFF_CONVERTER_ACTIVITY_STATUS = 8'h02;
  localparam logic [7:0] OFF_DRIVER_FAULT_EVENT_FLAGS = 8'h03;
  localparam logic [7:0] OFF_DRIVER_MISC_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] OFF_CONVERTER_EVENT_FLAGS = 8'h05;
  localparam logic [7:0] OFF_DRIVER_FAULT_EVENT_ENABLE = 8'h06;
  localparam logic [7:0] OFF_DRIVER_MISC_EVENT_ENABLE = 8'h07;
  localparam logic [7:0] OFF_CONVERTER_EVENT_ENABLE = 8'h08;

  // ==========================================================
  // field positions
  localparam int POS_FAULT_SUMMARY = 0;
  localparam int POS_CONVERTER_ACTIVE = 1;
  localparam int POS_FAULT_SUMMARY_CHANGE = 0;
  localparam int POS_SUPPLY_UNDERVOLTAGE = 1;
  localparam int POS_VIBRATION_TIMEOUT = 2;
  localparam int POS_AUTOTUNE_COMPLETE = 3;
  localparam int POS_CONVERSION_COMPLETE = 0;
  localparam int POS_CONVERTER_ACTIVITY_CHANGE = 1;
  // per-fault status bits 7..3 are faults; 2 is thermal too; 1..0 are clock and lock
  localparam int POS_FIRST_FAULT = 2;

  // ==========================================================
  // widths and reset values
  localparam int DATA_W = 8;
  localparam int MISC_W = 4;
  localparam int CONV_W = 2;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

endpackage

// File: logic/hefm_flag_reg.sv
/*
  sticky event flag register of parameter width: set wins over clear.
  assumes clear strobes come from a write-one-to-clear decode.
*/
`timescale 1ns/100ps
module hefm_flag_reg #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // set and clear strobes
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  // flag state
  output logic [WIDTH-1:0] flags_q
);
  import hefm_pkg::*;

  logic [WIDTH-1:0] flags_d;

  // refuse widths that the register port cannot read back
  if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
    $error("flag width out of range");
  end

  // ==========================================================
  // sticky update
  // hold until cleared
  assign flags_d = (flags_q & ~clr_in) | set_in;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule // hefm_flag_reg

// File: verif/hefm_top_tb_top.sv
/*
  self-checking bench for the haptic event flag and mask unit: register rows,
  event flags, masking, write-one-to-clear and reset.
  assumes hefm_top with its strobe register port and hefm_pkg.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module hefm_top_tb_top;
  import hefm_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} hefm_row_s;
  logic clk, rst, reg_wr, reg_rd, sup_uv, tmo, atd, cen, crun, cend;
  logic [7:0] reg_addr, reg_wdata, pfs;
  logic [DATA_W-1:0] reg_rdata_q;
  logic fault_summary_q, converter_active_q, irq_q;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  hefm_row_s rows [9] = '{'{8'h06, 8'ha5, 8'ha5}, '{8'h07, 8'hff, 8'h0f}, '{8'h08, 8'hff, 8'h03},
    '{8'h01, 8'hff, 8'h00}, '{8'h02, 8'hff, 8'h00}, '{8'h00, 8'hff, 8'h00}, '{8'h09, 8'hff, 8'h00},
    '{8'h03, 8'hff, 8'h00}, '{8'h06, 8'hff, 8'hff}};

  hefm_top i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .per_fault_status_in(pfs),
    .supply_undervoltage_in(sup_uv), .vibration_timeout_in(tmo), .autotune_done_in(atd),
    .converter_enabled_in(cen), .conversion_running_in(crun), .conversion_end_in(cend),
    .fault_summary_q(fault_summary_q), .converter_active_q(converter_active_q), .irq_q(irq_q)
  );

  // ==========================================================
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================================
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data launched at the taking edge stands here, so the bench stays on the edge grid
    @(posedge clk);
    `CHK(nm, e, reg_rdata_q)
  endtask
  task automatic clr();
    wr(8'h03, 8'hff);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
    cyc(2);
  endtask
  // pulses {autotune, timeout, conversion end} for one cycle
  task automatic ev(input logic [2:0] v);
    @(posedge clk);
    {atd, tmo, cend} <= v;
    @(posedge clk);
    {atd, tmo, cend} <= 3'b000;
    cyc(3);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, sup_uv, tmo, atd, cen, crun, cend} = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pfs = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    for (int a = 3; a <= 8; a++) begin
      rd("reset value", a[7:0], 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd("row readback", rows[i].a, rows[i].e);
    end
    // per-fault changes, summary and interrupt
    pfs <= 8'h81;
    cyc(4);
    `CHK("fault_summary", 1'b1, fault_summary_q)
    `CHK("irq", 1'b1, irq_q)
    rd("per_fault", 8'h00, 8'h81);
    rd("fault flags", 8'h03, 8'h81);
    rd("fault flags reread", 8'h03, 8'h81);
    rd("misc flags", 8'h04, 8'h01);
    rd("summary reg", 8'h01, 8'h01);
    wr(8'h03, 8'h01);
    rd("partial clear", 8'h03, 8'h80);
    clr();
    `CHK("irq cleared", 1'b0, irq_q)
    pfs <= 8'h03;
    cyc(4);
    `CHK("no fault", 1'b0, fault_summary_q)
    rd("fault flags 2", 8'h03, 8'h82);
    rd("misc flags 2", 8'h04, 8'h01);
    pfs <= 8'h00;
    cyc(4);
    clr();
    // pulse and level events
    ev(3'b100);
    rd("autotune", 8'h04, 8'h08);
    ev(3'b001);
    rd("conv end", 8'h05, 8'h01);
    clr();
    ev(3'b010);
    `CHK("timeout lock", 1'b1, fault_summary_q)
    rd("timeout", 8'h04, 8'h05);
    clr();
    cyc(2);
    `CHK("timeout unlock", 1'b0, fault_summary_q)
    clr();
    sup_uv <= 1'b1;
    cyc(4);
    `CHK("uv lock", 1'b1, fault_summary_q)
    rd("uv flag", 8'h04, 8'h03);
    sup_uv <= 1'b0;
    cyc(4);
    clr();
    // converter activity
    cen <= 1'b1;
    cyc(4);
    `CHK("enabled idle", 1'b0, converter_active_q)
    crun <= 1'b1;
    cyc(4);
    `CHK("converting", 1'b1, converter_active_q)
    rd("activity reg", 8'h02, 8'h02);
    rd("activity flag", 8'h05, 8'h02);
    {cen, crun} <= 2'b00;
    cyc(4);
    `CHK("disabled", 1'b0, converter_active_q)
    clr();
    // masking
    wr(8'h07, 8'h00);
    ev(3'b100);
    `CHK("misc masked", 1'b0, irq_q)
    wr(8'h07, 8'h08);
    cyc(2);
    `CHK("misc unmasked", 1'b1, irq_q)
    clr();
    `CHK("irq drop", 1'b0, irq_q)
    wr(8'h08, 8'h02);
    ev(3'b001);
    `CHK("conv masked", 1'b0, irq_q)
    wr(8'h08, 8'h01);
    cyc(2);
    `CHK("conv unmasked", 1'b1, irq_q)
    clr();
    wr(8'h06, 8'h7f);
    pfs <= 8'h80;
    cyc(4);
    `CHK("fault masked", 1'b0, irq_q)
    wr(8'h06, 8'h80);
    cyc(2);
    `CHK("fault unmasked", 1'b1, irq_q)
    pfs <= 8'h00;
    cyc(4);
    clr();
    // set beats a clear in the same cycle
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h04;
    reg_wdata <= 8'h08;
    atd <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    atd <= 1'b0;
    rd("set wins", 8'h04, 8'h08);
    // reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    `CHK("irq in reset", 1'b0, irq_q)
    rst <= 1'b0;
    cyc(2);
    rd("flags after reset", 8'h04, 8'h00);
    rd("enable after reset", 8'h06, 8'h00);
    end_sim();
  end
endmodule // hefm_top_tb_top
